/* File: nco_bank_pkg.sv */
package nco_bank_pkg;

  // Serial frame layout
  localparam int ADDR_BITS = 15;
  localparam int HDR_BITS  = 16;
  localparam int BYTE_BITS = 8;

  // Register offsets (byte addresses on the serial port)
  localparam logic [14:0] ADDR_SOFT_RESET         = 15'h0000;
  localparam logic [14:0] ADDR_FREQ_PRESET0       = 15'h0240;
  localparam logic [14:0] ADDR_PHASE_PRESET0      = 15'h0244;
  localparam logic [14:0] ADDR_FREQ_PRESET1       = 15'h0248;
  localparam logic [14:0] ADDR_PHASE_PRESET1      = 15'h024C;
  localparam logic [14:0] ADDR_FREQ_PRESET2       = 15'h0250;
  localparam logic [14:0] ADDR_PHASE_PRESET2      = 15'h0254;
  localparam logic [14:0] ADDR_FREQ_PRESET3       = 15'h0258;
  localparam logic [14:0] ADDR_PHASE_PRESET3      = 15'h025C;
  localparam logic [14:0] ADDR_STARTUP_STATUS     = 15'h0270;

  // Bank window layout: preset in offset bits 4:3, phase in bit 2
  localparam int          PRESET_LSB    = 3;
  localparam int          PHASE_SEL_BIT = 2;
  localparam logic [14:0] BANK_SPAN     = 15'h0020;

  // Field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int INIT_DONE_BIT  = 0;

  // Reset values
  localparam logic [31:0] FREQ_RESET  = 32'hC0000000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;

  // Counts
  localparam int NUM_PRESETS         = 4;
  localparam int FREQ_BITS           = 32;
  localparam int PHASE_BITS          = 16;
  localparam int INIT_CYCLES_DEFAULT = 64;

endpackage

/* File: spi_serial_port.sv */
module spi_serial_port (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        cs_n,
  output logic             sdo,
  output logic             sdo_oe_n,
  // Register side
  output logic             wr_pulse,
  output logic [14:0]      addr,
  output logic [7:0]       wdata,
  input  wire logic [7:0]  rdata
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HDR  = 3'b010,
    ST_DATA = 3'b100
  } port_state_e;

  logic [2:0]  sclk_sy_r;
  logic [1:0]  sdi_sy_r;
  logic [1:0]  cs_sy_r;
  port_state_e state_r, state_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        rd_r, rd_nxt;
  logic        load_r, load_nxt;
  logic [14:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        wr_r, wr_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic        rise;
  logic        fall;
  logic        sel;

  // Pins pass two flops, sclk three; only the second and later stages are read
  assign rise = sclk_sy_r[1] & ~sclk_sy_r[2];
  assign fall = ~sclk_sy_r[1] & sclk_sy_r[2];
  assign sel  = ~cs_sy_r[1];

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    rd_nxt    = rd_r;
    load_nxt  = load_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt    = 1'b0;
    oe_n_nxt  = oe_n_r;
    unique case (state_r)
      ST_IDLE:
      begin
        oe_n_nxt = 1'b1;
        cnt_nxt  = 5'h00;
        if (sel)
          state_nxt = ST_HDR;
      end
      ST_HDR:
      begin
        if (!sel)
          state_nxt = ST_IDLE;
        else if (rise)
        begin
          rx_nxt  = {rx_r[14:0], sdi_sy_r[1]};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == 5'(nco_bank_pkg::HDR_BITS - 1))
          begin
            rd_nxt    = rx_r[14];
            addr_nxt  = {rx_r[13:0], sdi_sy_r[1]};
            load_nxt  = 1'b1;
            cnt_nxt   = 5'h00;
            state_nxt = ST_DATA;
          end
        end
      end
      ST_DATA:
      begin
        if (!sel)
          state_nxt = ST_IDLE;
        else
        begin
          if (fall)
          begin
            if (load_r)
            begin
              tx_nxt   = rdata;
              load_nxt = 1'b0;
              oe_n_nxt = ~rd_r;
            end
            else
              tx_nxt = {tx_r[6:0], 1'b0};
          end
          if (rise)
          begin
            rx_nxt  = {rx_r[14:0], sdi_sy_r[1]};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(nco_bank_pkg::BYTE_BITS - 1))
            begin
              cnt_nxt   = 5'h00;
              wdata_nxt = {rx_r[6:0], sdi_sy_r[1]};
              wr_nxt    = ~rd_r;
              load_nxt  = 1'b1;
            end
          end
          // Address steps once a write byte's pulse has gone out, or on a read byte's last rising edge
          if (wr_r || (rise && rd_r &&
              cnt_r == 5'(nco_bank_pkg::BYTE_BITS - 1)))
            addr_nxt = addr_r + 15'h0001;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_sy_r <= 3'h0;
      sdi_sy_r  <= 2'h0;
      cs_sy_r   <= 2'h3;
      state_r   <= ST_IDLE;
      cnt_r     <= 5'h00;
      rx_r      <= 16'h0000;
      tx_r      <= 8'h00;
      rd_r      <= 1'b0;
      load_r    <= 1'b0;
      addr_r    <= 15'h0000;
      wdata_r   <= 8'h00;
      wr_r      <= 1'b0;
      oe_n_r    <= 1'b1;
    end
    else
    begin
      sclk_sy_r <= {sclk_sy_r[1:0], sclk};
      sdi_sy_r  <= {sdi_sy_r[0], sdi};
      cs_sy_r   <= {cs_sy_r[0], cs_n};
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      rx_r      <= rx_nxt;
      tx_r      <= tx_nxt;
      rd_r      <= rd_nxt;
      load_r    <= load_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      wr_r      <= wr_nxt;
      oe_n_r    <= oe_n_nxt;
    end
  end

  assign sdo      = tx_r[7];
  assign sdo_oe_n = oe_n_r;
  assign wr_pulse = wr_r;
  assign addr     = addr_r;
  assign wdata    = wdata_r;

endmodule // spi_serial_port

/* File: nco_preset_bank_chan_b.sv */
// Overview of operation
// - Four 32-bit frequency words, reset C0000000
// - Four 16-bit phase words, reset zero
// - Four independent presets, each freq and phase
// - Interleaved mode ignores this channel's words
// - Status bit 0 reads 1 after init
// - Phase left-justified into 32 bits
module nco_preset_bank_chan_b #(
  parameter int INIT_CYCLES = nco_bank_pkg::INIT_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial control port
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        cs_n,
  output logic             sdo,
  output logic             sdo_oe_n,
  // Converter mode
  input  wire logic        interleaved_mode,
  // Oscillator settings for this channel
  output logic [31:0]      osc_freq     [4],
  output logic [31:0]      osc_phase    [4],
  output logic             chan_b_active,
  output logic             init_done
);

  localparam int NP = nco_bank_pkg::NUM_PRESETS;
  localparam int CW = $clog2(INIT_CYCLES + 1);

  if (INIT_CYCLES < 1)
  begin : g_chk_init
    $error("INIT_CYCLES must be at least 1");
  end

  typedef enum logic [1:0] {
    INIT_RUN  = 2'b01,
    INIT_DONE = 2'b10
  } init_state_e;

  logic [31:0] freq_r     [NP];
  logic [31:0] freq_nxt   [NP];
  logic [15:0] phase_r    [NP];
  logic [15:0] phase_nxt  [NP];
  logic [31:0] ofreq_r    [NP];
  logic [31:0] ofreq_nxt  [NP];
  logic [31:0] ophase_r   [NP];
  logic [31:0] ophase_nxt [NP];
  init_state_e init_r, init_nxt;
  logic [CW-1:0] icnt_r, icnt_nxt;
  logic        active_r, active_nxt;
  logic        soft_rst;
  logic        wr_pulse;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  // Bank byte location of a serial address
  function automatic logic in_bank(input logic [14:0] a);
    return (a >= nco_bank_pkg::ADDR_FREQ_PRESET0) &&
           (a < nco_bank_pkg::ADDR_FREQ_PRESET0 + nco_bank_pkg::BANK_SPAN);
  endfunction

  function automatic logic [4:0] bank_off(input logic [14:0] a);
    logic [14:0] d;
    d = a - nco_bank_pkg::ADDR_FREQ_PRESET0;
    return d[4:0];
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] w,
                                           input logic [1:0]  lane,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = w;
    r[lane*8 +: 8] = b;
    return r;
  endfunction

  spi_serial_port u_port (
    .core_clk (core_clk),
    .reset    (reset),
    .sclk     (sclk),
    .sdi      (sdi),
    .cs_n     (cs_n),
    .sdo      (sdo),
    .sdo_oe_n (sdo_oe_n),
    .wr_pulse (wr_pulse),
    .addr     (addr),
    .wdata    (wdata),
    .rdata    (rdata)
  );

  // Soft reset is accepted even while initialization is running
  assign soft_rst = wr_pulse &&
                    addr == nco_bank_pkg::ADDR_SOFT_RESET &&
                    wdata[nco_bank_pkg::SOFT_RESET_BIT];

  // Initialization sequencer
  always_comb
  begin
    init_nxt = init_r;
    icnt_nxt = icnt_r;
    unique case (init_r)
      INIT_RUN:
      begin
        icnt_nxt = icnt_r + CW'(1);
        if (icnt_r == CW'(INIT_CYCLES - 1))
          init_nxt = INIT_DONE;
      end
      INIT_DONE:
        icnt_nxt = icnt_r;
      default:
        init_nxt = INIT_RUN;
    endcase
    if (soft_rst)
    begin
      init_nxt = INIT_RUN;
      icnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      init_r <= INIT_RUN;
      icnt_r <= '0;
    end
    else
    begin
      init_r <= init_nxt;
      icnt_r <= icnt_nxt;
    end
  end

  // Preset storage, written a byte at a time
  always_comb
  begin
    logic [4:0] off;
    int         p;
    off = bank_off(addr);
    p   = int'(off[4:nco_bank_pkg::PRESET_LSB]);
    for (int i = 0; i < NP; i++)
    begin
      freq_nxt[i]  = freq_r[i];
      phase_nxt[i] = phase_r[i];
    end
    if (soft_rst)
    begin
      for (int i = 0; i < NP; i++)
      begin
        freq_nxt[i]  = nco_bank_pkg::FREQ_RESET;
        phase_nxt[i] = nco_bank_pkg::PHASE_RESET;
      end
    end
    else if (wr_pulse && in_bank(addr))
    begin
      if (!off[nco_bank_pkg::PHASE_SEL_BIT])
        freq_nxt[p] = put_byte(freq_r[p], off[1:0], wdata);
      else if (!off[1])
        phase_nxt[p] = 16'(put_byte({16'h0000, phase_r[p]},
                                    off[1:0], wdata));
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NP; i++)
      begin
        freq_r[i]  <= nco_bank_pkg::FREQ_RESET;
        phase_r[i] <= nco_bank_pkg::PHASE_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NP; i++)
      begin
        freq_r[i]  <= freq_nxt[i];
        phase_r[i] <= phase_nxt[i];
      end
    end
  end

  // Read multiplexer
  always_comb
  begin
    logic [4:0]  off;
    logic [31:0] w;
    int          p;
    off   = bank_off(addr);
    p     = int'(off[4:nco_bank_pkg::PRESET_LSB]);
    w     = 32'h00000000;
    rdata = 8'h00;
    if (in_bank(addr))
    begin
      if (off[nco_bank_pkg::PHASE_SEL_BIT])
        w = {16'h0000, phase_r[p]};
      else
        w = freq_r[p];
      rdata = w[off[1:0]*8 +: 8];
    end
    else if (addr == nco_bank_pkg::ADDR_STARTUP_STATUS)
      rdata[nco_bank_pkg::INIT_DONE_BIT] = (init_r == INIT_DONE);
  end

  // Settings handed to the oscillator, held off in interleaved mode
  always_comb
  begin
    active_nxt = ~interleaved_mode;
    for (int i = 0; i < NP; i++)
    begin
      if (interleaved_mode)
      begin
        ofreq_nxt[i]  = 32'h00000000;
        ophase_nxt[i] = 32'h00000000;
      end
      else
      begin
        ofreq_nxt[i]  = freq_r[i];
        ophase_nxt[i] = {phase_r[i], 16'h0000};
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      active_r <= 1'b0;
      for (int i = 0; i < NP; i++)
      begin
        ofreq_r[i]  <= 32'h00000000;
        ophase_r[i] <= 32'h00000000;
      end
    end
    else
    begin
      active_r <= active_nxt;
      for (int i = 0; i < NP; i++)
      begin
        ofreq_r[i]  <= ofreq_nxt[i];
        ophase_r[i] <= ophase_nxt[i];
      end
    end
  end

  assign osc_freq      = ofreq_r;
  assign osc_phase     = ophase_r;
  assign chan_b_active = active_r;
  // One-hot done bit taken straight from the state flop
  assign init_done     = init_r[1];

endmodule // nco_preset_bank_chan_b

/* File: nco_preset_bank_chan_b_props.sv */
module nco_bank_checker #(
  parameter int INIT_CYCLES = 4
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Watched ports
  input wire logic        cs_n,
  input wire logic        sdo_oe_n,
  input wire logic        interleaved_mode,
  input wire logic [31:0] osc_freq [4],
  input wire logic [31:0] osc_phase [4],
  input wire logic        chan_b_active,
  input wire logic        init_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned wait_r;
  int unsigned wait_nxt;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Cycles spent waiting for the done flag
  always_comb
  begin
    wait_nxt = init_done ? 0 : wait_r + 1;
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      wait_r <= 0;
    else
      wait_r <= wait_nxt;
  end

  a_freq_gated: assert property (
    interleaved_mode[*2] |=> (osc_freq[0] | osc_freq[1] | osc_freq[2]
      | osc_freq[3]) == 32'h0)
    else $error("freq output live in interleaved mode");
  a_phase_gated: assert property (
    interleaved_mode[*2] |=> (osc_phase[0] | osc_phase[1] | osc_phase[2]
      | osc_phase[3]) == 32'h0)
    else $error("phase output live in interleaved mode");
  a_active_flag: assert property (
    $changed(interleaved_mode) |=> chan_b_active == !$past(interleaved_mode))
    else $error("active flag wrong after mode change");
  a_phase_padded: assert property (
    (osc_phase[0][15:0] | osc_phase[1][15:0] | osc_phase[2][15:0]
      | osc_phase[3][15:0]) == 16'h0)
    else $error("phase low half not zero");
  a_freq_reset: assert property (
    $fell(reset) && !interleaved_mode |-> ##2
      osc_freq[0] == nco_bank_pkg::FREQ_RESET
      && osc_freq[3] == nco_bank_pkg::FREQ_RESET)
    else $error("freq not at reset value");
  a_phase_reset: assert property (
    $fell(reset) |-> ##2 osc_phase[0] == 32'h0 && osc_phase[3] == 32'h0)
    else $error("phase not at reset value");
  a_init_bound: assert property (
    wait_r <= INIT_CYCLES + 3)
    else $error("done flag late");
  a_init_early: assert property (
    $rose(init_done) |-> wait_r >= INIT_CYCLES - 1)
    else $error("done flag early");
  a_words_hold: assert property (
    cs_n[*6] ##1 (cs_n && !interleaved_mode)[*3] |=>
      $stable(osc_freq[0]) && $stable(osc_phase[0]))
    else $error("word changed with no access");
  a_sdo_release: assert property (
    cs_n[*6] |-> sdo_oe_n)
    else $error("data-out still driven after deselect");
endmodule // nco_bank_checker

bind nco_preset_bank_chan_b nco_bank_checker #(.INIT_CYCLES(INIT_CYCLES))
  u_nco_bank_checker (.core_clk, .reset, .cs_n, .sdo_oe_n, .interleaved_mode,
  .osc_freq, .osc_phase, .chan_b_active, .init_done);

/* File: spi_host_model.sv */
module spi_host_model (
  // Clock
  input  wire logic        core_clk,
  // Serial pins
  input  wire logic        sdo,
  output logic             sclk,
  output logic             sdi,
  output logic             cs_n,
  // Read result
  output logic             rd_valid,
  output logic [31:0]      rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 8;

  initial
  begin
    sclk = 1'b0;
    sdi = 1'b1;
    cs_n = 1'b1;
    rd_valid = 1'b0;
    rd_data = 32'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bytes go least significant first, each MSB first
  task automatic xfer(input logic rd, input logic [14:0] a, input int nb,
                      input logic [31:0] wd);
    logic [47:0] f;
    f = {rd, a, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
    rd_data = 32'h0;
    tick(1);
    cs_n = 1'b0;
    for (int k = 0; k < 16 + 8 * nb; k++)
    begin
      sdi = f[47 - k];
      tick(HALF);
      if (rd && k >= 16)
        rd_data[8 * ((k - 16) / 8) + 7 - (k - 16) % 8] = sdo;
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
    end
    // Released data line shows the inverse of its last bit
    sdi = ~sdi;
    tick(HALF);
    cs_n = 1'b1;
    rd_valid = rd;
    tick(1);
    rd_valid = 1'b0;
    tick(HALF);
  endtask
endmodule // spi_host_model

/* File: nco_preset_bank_chan_b_tb_top.sv */
module nco_preset_bank_chan_b_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [14:0] F0 = nco_bank_pkg::ADDR_FREQ_PRESET0;
  localparam logic [14:0] P0 = nco_bank_pkg::ADDR_PHASE_PRESET0;
  localparam logic [14:0] ST = nco_bank_pkg::ADDR_STARTUP_STATUS;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        interleaved_mode = 1'b0;
  logic        sclk, sdi, cs_n, sdo, sdo_oe_n;
  logic        chan_b_active, init_done, rd_valid;
  logic [31:0] osc_freq [4];
  logic [31:0] osc_phase [4];
  logic [31:0] rd_data, fw[4], pw[4];
  logic [31:0] exp_q[$];
  logic        oe_low = 1'b0;
  int          errors = 0;
  int          checks = 0;

  always #20 core_clk = ~core_clk;

  nco_preset_bank_chan_b #(.INIT_CYCLES(4)) u_nco_preset_bank_chan_b (
    .core_clk, .reset, .sclk, .sdi, .cs_n, .sdo, .sdo_oe_n,
    .interleaved_mode, .osc_freq, .osc_phase, .chan_b_active, .init_done);
  spi_host_model u_spi_host_model (
    .core_clk, .sdo, .sclk, .sdi, .cs_n, .rd_valid, .rd_data);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic rd(input logic [14:0] a, input int nb, input logic [31:0] e);
    exp_q.push_back(e);
    u_spi_host_model.xfer(1'b1, a, nb, 32'h0);
  endtask

  task automatic wr(input logic [14:0] a, input int nb, input logic [31:0] d);
    u_spi_host_model.xfer(1'b0, a, nb, d);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (init_done !== 1'b1)
    begin
      errors++;
      finish_test();
    end
  endtask

  // Read results are matched against the oldest note
  always @(posedge core_clk)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(rd_data, 32'hFFFFFFFF);
      else
        check(rd_data, exp_q.pop_front());
    end

  // Notes whether the device has driven its data-out pin
  always @(posedge core_clk)
    if (sdo_oe_n === 1'b0)
      oe_low = 1'b1;

  initial
  begin
    void'($urandom(17825));
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    check(init_done, 32'h0);
    wait_done();
    check(chan_b_active, 32'h1);
    rd(ST, 1, 32'h1);
    check(oe_low, 32'h1);
    check(sdo_oe_n, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      rd(F0 + 15'(8 * i), 4, nco_bank_pkg::FREQ_RESET);
      rd(P0 + 15'(8 * i), 2, 32'(nco_bank_pkg::PHASE_RESET));
      check(osc_freq[i], nco_bank_pkg::FREQ_RESET);
    end
    $display("reset values test done");
    oe_low = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      fw[i] = $urandom;
      pw[i] = $urandom;
      wr(F0 + 15'(8 * i), 4, fw[i]);
      wr(P0 + 15'(8 * i), 2, pw[i]);
    end
    check(oe_low, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rd(F0 + 15'(8 * i), 4, fw[i]);
      rd(P0 + 15'(8 * i), 2, {16'h0, pw[i][15:0]});
      check(osc_freq[i], fw[i]);
      check(osc_phase[i], {pw[i][15:0], 16'h0});
    end
    wr(ST, 1, 32'hFE);
    rd(ST, 1, 32'h1);
    $display("preset write test done");
    interleaved_mode = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check(chan_b_active, 32'h0);
    for (int i = 0; i < 4; i++)
      check(osc_freq[i] | osc_phase[i], 32'h0);
    interleaved_mode = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check(osc_freq[2], fw[2]);
    $display("interleaved test done");
    wr(nco_bank_pkg::ADDR_SOFT_RESET, 1, 32'h80);
    wait_done();
    rd(F0, 4, nco_bank_pkg::FREQ_RESET);
    rd(P0 + 15'h8, 2, 32'h0);
    rd(ST, 1, 32'h1);
    $display("soft reset test done");
    check(32'(exp_q.size()), 32'h0);
    finish_test();
  end
endmodule // nco_preset_bank_chan_b_tb_top
